// ==== ces_cmd_handler.sv ====
// erase and application start command handler
`timescale 1ns/100ps
module ces_cmd_handler (
  // clock and reset
  input  wire logic                   I_CLK_SYS,
  input  wire logic                   I_RESET,
  // received frames
  input  wire logic                   I_RX_VALID,
  input  wire ces_pkg::ces_rx_frame_t I_RX_FRAME,
  // session and protection state
  input  wire logic                   I_COMM_OPEN,
  input  wire logic                   I_PROG_PROTECTED,
  // flash eraser
  output logic                        O_ERASE_REQ,
  output ces_pkg::ces_range_t         O_ERASE_RANGE,
  input  wire logic                   I_ERASE_DONE,
  // configuration byte defaults
  output logic                        O_CFG_WR,
  output ces_pkg::ces_cfg_t           O_CFG,
  // reply frames
  output logic                        O_TX_VALID,
  output ces_pkg::ces_tx_frame_t      O_TX_FRAME,
  input  wire logic                   I_TX_READY,
  // application start
  output logic                        O_WDT_ENABLE,
  output logic                        O_JUMP_VALID,
  output logic [15:0]                 O_JUMP_ADDR,
  // status
  output logic                        O_BUSY
);
  import ces_pkg::*;

  ces_state_t    state;
  ces_state_t    next_state;
  logic          next_erase_req;
  ces_range_t    next_erase_range;
  logic          full_erase;
  logic          next_full_erase;
  logic          next_cfg_wr;
  logic          next_tx_valid;
  ces_tx_frame_t next_tx_frame;
  logic          next_wdt_enable;
  logic          next_jump_valid;
  logic [15:0]   next_jump_addr;

  // frame decode
  wire logic take      = I_RX_VALID && (state == ST_IDLE) && I_COMM_OPEN
                         && I_RX_FRAME.write_cmd_frame_id;
  wire logic erase_cmd = take && (I_RX_FRAME.len == LEN_ERASE) && (I_RX_FRAME.d0 == CMD_ERASE);
  wire logic full_sel  = (I_RX_FRAME.d1 == SEL_FULL_CHIP);
  wire logic start_cmd = take && (I_RX_FRAME.d0 == CMD_START);
  wire logic wdt_cmd   = start_cmd && (I_RX_FRAME.len == LEN_START_WDT)
                         && (I_RX_FRAME.d1 == START_WATCHDOG);
  wire logic jump_cmd  = start_cmd && (I_RX_FRAME.len == LEN_START_JUMP)
                         && (I_RX_FRAME.d1 == START_JUMP);

  // region select per block
  logic [NUM_BLOCKS-1:0] blk_hit;
  ces_range_t            blk_range [NUM_BLOCKS];
  genvar gi;
  generate
    for (gi = 0; gi < NUM_BLOCKS; gi++) begin : g_blk
      assign blk_hit[gi]         = (I_RX_FRAME.d1 == BLK_SEL[gi]);
      assign blk_range[gi].first = blk_hit[gi] ? BLK_FIRST[gi] : RST_ADDR;
      assign blk_range[gi].last  = blk_hit[gi] ? BLK_LAST[gi]  : RST_ADDR;
    end
  endgenerate

  ces_range_t sel_range;
  always_comb begin
    sel_range = '{first: RST_ADDR, last: RST_ADDR};
    for (int i = 0; i < NUM_BLOCKS; i++) begin
      sel_range.first = sel_range.first | blk_range[i].first;
      sel_range.last  = sel_range.last  | blk_range[i].last;
    end
  end

  wire logic full_erase_cmd = erase_cmd && full_sel;
  wire logic blk_erase_cmd  = erase_cmd && !full_sel && (|blk_hit);
  wire logic [15:0] rx_addr = {I_RX_FRAME.d2, I_RX_FRAME.d3};

  wire ces_tx_frame_t ack_frame = '{error_frame_id: 1'b0, len: LEN_REPLY, d0: ACK_CODE};
  wire ces_tx_frame_t err_frame = '{error_frame_id: 1'b1, len: LEN_REPLY, d0: ERR_SECURITY};

  always_comb begin
    next_state       = state;
    next_erase_req   = O_ERASE_REQ;
    next_erase_range = O_ERASE_RANGE;
    next_full_erase  = full_erase;
    next_cfg_wr      = 1'b0;
    next_tx_valid    = O_TX_VALID;
    next_tx_frame    = O_TX_FRAME;
    next_wdt_enable  = O_WDT_ENABLE;
    next_jump_valid  = 1'b0;
    next_jump_addr   = O_JUMP_ADDR;
    unique case (state)
      ST_IDLE: begin
        if (full_erase_cmd) begin
          // security byte is not consulted here
          next_state       = ST_ERASE;
          next_erase_req   = 1'b1;
          next_erase_range = '{first: FLASH_FIRST, last: FLASH_LAST};
          next_full_erase  = 1'b1;
        end else if (blk_erase_cmd) begin
          if (I_PROG_PROTECTED) begin
            next_state    = ST_REPLY;
            next_tx_valid = 1'b1;
            next_tx_frame = err_frame;
          end else begin
            next_state       = ST_ERASE;
            next_erase_req   = 1'b1;
            next_erase_range = sel_range;
            next_full_erase  = 1'b0;
          end
        end else if (wdt_cmd) begin
          // wait here until the watchdog resets the device, nothing is sent
          next_state      = ST_HALT;
          next_wdt_enable = 1'b1;
        end else if (jump_cmd) begin
          next_jump_valid = 1'b1;
          next_jump_addr  = rx_addr;
        end
      end
      ST_ERASE: begin
        if (I_ERASE_DONE) begin
          next_erase_req = 1'b0;
          next_cfg_wr    = full_erase;
          next_state     = ST_REPLY;
          next_tx_valid  = 1'b1;
          next_tx_frame  = ack_frame;
        end
      end
      ST_REPLY: begin
        if (I_TX_READY) begin
          next_tx_valid = 1'b0;
          next_state    = ST_IDLE;
        end
      end
      ST_HALT: begin
        next_state = ST_HALT;
      end
    endcase
  end

  // sequencer state
  always_ff @(posedge I_CLK_SYS or posedge I_RESET) begin
    if (I_RESET) begin
      state <= ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // erase request towards the flash eraser
  always_ff @(posedge I_CLK_SYS or posedge I_RESET) begin
    if (I_RESET) begin
      O_ERASE_REQ <= 1'b0;
    end else begin
      O_ERASE_REQ <= next_erase_req;
    end
  end

  // erase range, held while the request stands
  always_ff @(posedge I_CLK_SYS or posedge I_RESET) begin
    if (I_RESET) begin
      O_ERASE_RANGE <= '{first: RST_ADDR, last: RST_ADDR};
    end else begin
      O_ERASE_RANGE <= next_erase_range;
    end
  end

  // remembers whether the running erase covers the whole flash
  always_ff @(posedge I_CLK_SYS or posedge I_RESET) begin
    if (I_RESET) begin
      full_erase <= 1'b0;
    end else begin
      full_erase <= next_full_erase;
    end
  end

  // one-cycle load strobe for the configuration bytes
  always_ff @(posedge I_CLK_SYS or posedge I_RESET) begin
    if (I_RESET) begin
      O_CFG_WR <= 1'b0;
    end else begin
      O_CFG_WR <= next_cfg_wr;
    end
  end

  // reply valid, held until the transmitter takes it
  always_ff @(posedge I_CLK_SYS or posedge I_RESET) begin
    if (I_RESET) begin
      O_TX_VALID <= 1'b0;
    end else begin
      O_TX_VALID <= next_tx_valid;
    end
  end

  // reply frame contents
  always_ff @(posedge I_CLK_SYS or posedge I_RESET) begin
    if (I_RESET) begin
      O_TX_FRAME <= '{error_frame_id: 1'b0, len: '0, d0: '0};
    end else begin
      O_TX_FRAME <= next_tx_frame;
    end
  end

  // watchdog enable, sticky until the watchdog reset arrives
  always_ff @(posedge I_CLK_SYS or posedge I_RESET) begin
    if (I_RESET) begin
      O_WDT_ENABLE <= 1'b0;
    end else begin
      O_WDT_ENABLE <= next_wdt_enable;
    end
  end

  // jump strobe, one cycle per accepted jump start frame (none for the watchdog start)
  always_ff @(posedge I_CLK_SYS or posedge I_RESET) begin
    if (I_RESET) begin
      O_JUMP_VALID <= 1'b0;
    end else begin
      O_JUMP_VALID <= next_jump_valid;
    end
  end

  // last jump target
  always_ff @(posedge I_CLK_SYS or posedge I_RESET) begin
    if (I_RESET) begin
      O_JUMP_ADDR <= RST_ADDR;
    end else begin
      O_JUMP_ADDR <= next_jump_addr;
    end
  end

  // busy mirrors the next state so that it comes straight from a flop
  always_ff @(posedge I_CLK_SYS or posedge I_RESET) begin
    if (I_RESET) begin
      O_BUSY <= 1'b0;
    end else begin
      O_BUSY <= (next_state != ST_IDLE);
    end
  end

  // defaults are constant; written every cycle, not only together with O_CFG_WR
  always_ff @(posedge I_CLK_SYS or posedge I_RESET) begin
    if (I_RESET) begin
      O_CFG <= '{CFG_DEFAULT, CFG_DEFAULT, CFG_DEFAULT};
    end else begin
      O_CFG <= '{CFG_DEFAULT, CFG_DEFAULT, CFG_DEFAULT};
    end
  end

endmodule : ces_cmd_handler

// ==== ces_pkg.sv ====
// constants and types for the erase and application start command handler
// Functional notes
// - act on commands only with communication open
// - full erase clears flash, config bytes to FFh
// - block erase clears only selected region
// - erase frame: length 2, 00h, region select
// - protected block erase answers error, else acknowledge
// - full erase ignores security byte setting
// - full erase acknowledged with length-1 00h frame
// - start 03h 00h enables watchdog, then idles
// - start 03h 01h plus address jumps, no reset
// - no reply to any start command
// - error frame: error id, length 1, 00h
package ces_pkg;

  localparam logic [7:0]  CMD_ERASE      = 8'h00;
  localparam logic [7:0]  CMD_START      = 8'h03;
  localparam logic [7:0]  SEL_FULL_CHIP  = 8'hFF;
  localparam logic [7:0]  START_WATCHDOG = 8'h00;
  localparam logic [7:0]  START_JUMP     = 8'h01;
  localparam logic [7:0]  ACK_CODE       = 8'h00;
  localparam logic [7:0]  ERR_SECURITY   = 8'h00;
  localparam logic [7:0]  CFG_DEFAULT    = 8'hFF;
  localparam logic [3:0]  LEN_ERASE      = 4'h2;
  localparam logic [3:0]  LEN_START_WDT  = 4'h2;
  localparam logic [3:0]  LEN_START_JUMP = 4'h4;
  localparam logic [3:0]  LEN_REPLY      = 4'h1;
  localparam logic [15:0] FLASH_FIRST    = 16'h0000;
  localparam logic [15:0] FLASH_LAST     = 16'hFFFF;
  localparam logic [15:0] RST_ADDR       = 16'h0000;

  localparam int NUM_BLOCKS = 5;
  localparam logic [7:0]  BLK_SEL   [NUM_BLOCKS] = '{8'h00, 8'h20, 8'h40, 8'h80, 8'hC0};
  localparam logic [15:0] BLK_FIRST [NUM_BLOCKS] = '{16'h0000, 16'h2000, 16'h4000, 16'h8000, 16'hC000};
  localparam logic [15:0] BLK_LAST  [NUM_BLOCKS] = '{16'h1FFF, 16'h3FFF, 16'h7FFF, 16'hBFFF, 16'hFFFF};

  // received frame, already sorted by identifier in the can controller
  typedef struct packed {
    logic       write_cmd_frame_id;
    logic [3:0] len;
    logic [7:0] d0;
    logic [7:0] d1;
    logic [7:0] d2;
    logic [7:0] d3;
  } ces_rx_frame_t;

  // reply frame: error_frame_id when err is set, else write_cmd_frame_ident
  typedef struct packed {
    logic       error_frame_id;
    logic [3:0] len;
    logic [7:0] d0;
  } ces_tx_frame_t;

  typedef struct packed {
    logic [15:0] first;
    logic [15:0] last;
  } ces_range_t;

  // defaults loaded into the boot status, soft boot vector and security bytes
  typedef struct packed {
    logic [7:0] boot_status_byte;
    logic [7:0] soft_boot_vector;
    logic [7:0] software_security_byte;
  } ces_cfg_t;

  typedef enum logic [1:0] {ST_IDLE, ST_ERASE, ST_REPLY, ST_HALT} ces_state_t;

endpackage : ces_pkg

// ==== ces_cmd_handler_checker.sv ====
// port assertions for the command handler
`timescale 1ns/100ps
module ces_cmd_handler_checker (
  input wire logic                   I_CLK_SYS,
  input wire logic                   I_RESET,
  input wire logic                   I_RX_VALID,
  input wire ces_pkg::ces_rx_frame_t I_RX_FRAME,
  input wire logic                   I_COMM_OPEN,
  input wire logic                   I_PROG_PROTECTED,
  input wire logic                   O_ERASE_REQ,
  input wire ces_pkg::ces_range_t    O_ERASE_RANGE,
  input wire logic                   I_ERASE_DONE,
  input wire logic                   O_CFG_WR,
  input wire ces_pkg::ces_cfg_t      O_CFG,
  input wire logic                   O_TX_VALID,
  input wire ces_pkg::ces_tx_frame_t O_TX_FRAME,
  input wire logic                   I_TX_READY,
  input wire logic                   O_WDT_ENABLE,
  input wire logic                   O_JUMP_VALID,
  input wire logic [15:0]            O_JUMP_ADDR,
  input wire logic                   O_BUSY
);
  import ces_pkg::*;
  default clocking @(posedge I_CLK_SYS); endclocking
  default disable iff (I_RESET);
  wire take = I_RX_VALID && !O_BUSY && I_COMM_OPEN && I_RX_FRAME.write_cmd_frame_id;
  wire era = take && I_RX_FRAME.len == LEN_ERASE && I_RX_FRAME.d0 == CMD_ERASE;
  wire jmp = take && I_RX_FRAME.len == LEN_START_JUMP && I_RX_FRAME.d0 == CMD_START && I_RX_FRAME.d1 == START_JUMP;
  wire [15:0] jaddr = {I_RX_FRAME.d2, I_RX_FRAME.d3};
  chk_full_erase_start: assert property (
    era && I_RX_FRAME.d1 == SEL_FULL_CHIP |=> O_ERASE_REQ && O_ERASE_RANGE == {FLASH_FIRST, FLASH_LAST} && !O_TX_VALID)
    else $error("full erase not started");
  chk_prot_error: assert property (
    era && I_PROG_PROTECTED && I_RX_FRAME.d1 inside {8'h00, 8'h20, 8'h40, 8'h80, 8'hC0}
    |=> !O_ERASE_REQ && O_TX_VALID && O_TX_FRAME.error_frame_id) else $error("protected erase not refused");
  chk_done_ack: assert property (
    O_ERASE_REQ && I_ERASE_DONE |=> !O_ERASE_REQ && O_TX_VALID && !O_TX_FRAME.error_frame_id)
    else $error("no ack after erase");
  chk_cfg_default: assert property (
    O_CFG_WR |-> O_CFG == {3{CFG_DEFAULT}} && $past(O_ERASE_RANGE) == {FLASH_FIRST, FLASH_LAST})
    else $error("config defaults wrong");
  chk_reply_format: assert property (
    O_TX_VALID |-> O_TX_FRAME.len == LEN_REPLY && O_TX_FRAME.d0 == ACK_CODE) else $error("reply format");
  chk_tx_hold: assert property (
    O_TX_VALID && !I_TX_READY |=> O_TX_VALID && $stable(O_TX_FRAME)) else $error("reply dropped");
  chk_jump_addr: assert property (
    jmp |=> O_JUMP_VALID && O_JUMP_ADDR == $past(jaddr)) else $error("jump wrong");
  chk_jump_quiet: assert property (
    !jmp |=> !O_JUMP_VALID) else $error("jump without start frame");
  chk_start_silent: assert property (
    O_JUMP_VALID || O_WDT_ENABLE |-> !O_TX_VALID && !O_ERASE_REQ) else $error("start replied");
  chk_wdt_stay: assert property (
    O_WDT_ENABLE |=> O_WDT_ENABLE && O_BUSY) else $error("watchdog start left");
  chk_closed_drop: assert property (
    I_RX_VALID && !O_BUSY && !I_COMM_OPEN |=> !O_BUSY && !O_JUMP_VALID) else $error("closed frame acted on");
endmodule : ces_cmd_handler_checker

bind ces_cmd_handler ces_cmd_handler_checker i_chk (.I_CLK_SYS(I_CLK_SYS), .I_RESET(I_RESET),
  .I_RX_VALID(I_RX_VALID), .I_RX_FRAME(I_RX_FRAME), .I_COMM_OPEN(I_COMM_OPEN),
  .I_PROG_PROTECTED(I_PROG_PROTECTED), .O_ERASE_REQ(O_ERASE_REQ), .O_ERASE_RANGE(O_ERASE_RANGE),
  .I_ERASE_DONE(I_ERASE_DONE), .O_CFG_WR(O_CFG_WR), .O_CFG(O_CFG), .O_TX_VALID(O_TX_VALID),
  .O_TX_FRAME(O_TX_FRAME), .I_TX_READY(I_TX_READY), .O_WDT_ENABLE(O_WDT_ENABLE),
  .O_JUMP_VALID(O_JUMP_VALID), .O_JUMP_ADDR(O_JUMP_ADDR), .O_BUSY(O_BUSY));

// ==== ces_far_model.sv ====
// far side model: eraser with random latency and a stalling reply receiver
`timescale 1ns/100ps
module ces_far_model (
  // clock and reset
  input  wire logic i_clk,
  input  wire logic i_reset,
  // requests from the handler
  input  wire logic i_erase_req,
  // answers
  output logic      o_erase_done,
  output logic      o_tx_ready
);
  int wait_cnt;
  always @(negedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      o_erase_done <= 1'b0;
      o_tx_ready   <= 1'b0;
      wait_cnt     <= 0;
    end else begin
      o_tx_ready   <= 1'($urandom_range(1, 0));
      o_erase_done <= 1'b0;
      if (!i_erase_req) wait_cnt <= $urandom_range(6, 0);
      else if (wait_cnt > 0) wait_cnt <= wait_cnt - 1;
      else if (!o_erase_done) o_erase_done <= 1'b1;
    end
  end
endmodule : ces_far_model

// ==== ces_cmd_handler_tb.sv ====
// self-checking bench for the command handler
`timescale 1ns/100ps
module ces_cmd_handler_tb;
  import ces_pkg::*;
  logic clk = 0, rst = 1, rx_valid = 0, comm_open = 1, prot = 0;
  logic erase_req, cfg_wr, tx_valid, tx_ready, erase_done, wdt_en, jump_valid, busy;
  logic [15:0] jump_addr, a;
  ces_rx_frame_t rx_frame = '0;
  ces_range_t range;
  ces_cfg_t cfg;
  ces_tx_frame_t tx_frame, last_tx;
  int miscompares = 0, check_count = 0, cyc = 0, tx_n = 0, erase_n = 0, cfg_n = 0, k;
  always #5 clk = ~clk;
  ces_cmd_handler i_dut (.I_CLK_SYS(clk), .I_RESET(rst), .I_RX_VALID(rx_valid), .I_RX_FRAME(rx_frame),
    .I_COMM_OPEN(comm_open), .I_PROG_PROTECTED(prot), .O_ERASE_REQ(erase_req), .O_ERASE_RANGE(range),
    .I_ERASE_DONE(erase_done), .O_CFG_WR(cfg_wr), .O_CFG(cfg), .O_TX_VALID(tx_valid), .O_TX_FRAME(tx_frame),
    .I_TX_READY(tx_ready), .O_WDT_ENABLE(wdt_en), .O_JUMP_VALID(jump_valid), .O_JUMP_ADDR(jump_addr),
    .O_BUSY(busy));
  ces_far_model i_far (.i_clk(clk), .i_reset(rst), .i_erase_req(erase_req), .o_erase_done(erase_done),
    .o_tx_ready(tx_ready));
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (tx_valid && tx_ready) tx_n <= tx_n + 1;
    if (tx_valid && tx_ready) last_tx <= tx_frame;
    if (erase_req && erase_done) erase_n <= erase_n + 1;
    if (cfg_wr) cfg_n <= cfg_n + 1;
    if (cyc == 20000) begin
      miscompares++;
      give_verdict();
    end
  end
  task give_verdict();
    if (miscompares == 0 && check_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : give_verdict
  task check(input string name, input logic [63:0] seen, input logic [63:0] exp);
    check_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task send(input logic id, input logic [3:0] len, input logic [7:0] b0, b1, b2, b3);
    @(negedge clk);
    rx_frame = {id, len, b0, b1, b2, b3};
    rx_valid = 1'b1;
    @(negedge clk);
    rx_valid = 1'b0;
  endtask : send
  function automatic logic [7:0] sel_of(int i);
    return (i == 5) ? SEL_FULL_CHIP : BLK_SEL[i];
  endfunction : sel_of
  function automatic logic [31:0] rng_of(int i);
    return (i == 5) ? {FLASH_FIRST, FLASH_LAST} : {BLK_FIRST[i], BLK_LAST[i]};
  endfunction : rng_of
  task erase_chk(input int i, input logic pr);
    int n, e, c;
    logic err;
    n = tx_n;
    e = erase_n;
    c = cfg_n;
    err = pr && i != 5;
    prot = pr;
    send(1'b1, LEN_ERASE, CMD_ERASE, sel_of(i), 8'h00, 8'h00);
    if (err) check("refusal", {erase_req, tx_valid, tx_frame}, {2'b01, 1'b1, LEN_REPLY, ERR_SECURITY});
    else check("range", {erase_req, range}, {1'b1, rng_of(i)});
    for (int w = 0; w < 200 && busy !== 1'b0; w++) @(negedge clk);
    check("replies", tx_n - n, 1);
    check("reply", last_tx, {err, LEN_REPLY, ACK_CODE});
    check("erases", erase_n - e, !err);
    check("cfg", {cfg_n - c, cfg}, {i == 5, {3{CFG_DEFAULT}}});
  endtask : erase_chk
  initial begin
    void'($urandom(32'h7ede8845));
    repeat (10) @(negedge clk);
    rst = 0;
    for (k = 0; k < 12; k++) erase_chk(k % 6, k > 5);
    repeat (30) begin
      k = $urandom_range(2, 0);
      comm_open = (k != 0);
      send(k != 1, LEN_ERASE, CMD_ERASE, (k == 2) ? 8'h10 : sel_of($urandom_range(5, 0)), 8'h00, 8'h00);
      check("ignored", {busy, tx_valid, erase_req}, 0);
    end
    comm_open = 1;
    repeat (8) begin
      a = 16'($urandom);
      send(1'b1, LEN_START_JUMP, CMD_START, START_JUMP, a[15:8], a[7:0]);
      check("jump", {jump_valid, jump_addr, busy, tx_valid}, {1'b1, a, 2'b00});
    end
    send(1'b1, LEN_START_WDT, CMD_START, START_WATCHDOG, 8'h00, 8'h00);
    repeat (20) @(negedge clk);
    send(1'b1, LEN_START_JUMP, CMD_START, START_JUMP, 8'h12, 8'h34);
    check("watchdog", {wdt_en, busy, tx_valid, jump_valid}, 4'b1100);
    rst = 1;
    @(negedge clk);
    rst = 0;
    check("restart", {wdt_en, busy}, 0);
    send(1'b1, LEN_START_JUMP, CMD_START, START_JUMP, 8'h56, 8'h78);
    check("relaunch", {jump_valid, jump_addr, busy}, {1'b1, 16'h5678, 1'b0});
    give_verdict();
  end
endmodule : ces_cmd_handler_tb
